// >>> logic/fbc_defs.vh
// Constants for the flash bus controller: register map, fields, timing.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef FBC_DEFS_VH
`define FBC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FBC_REG_CTRL 4'h0
`define FBC_REG_ADDR 4'h1
`define FBC_REG_WDATA 4'h2
`define FBC_REG_RDATA 4'h3
`define FBC_REG_STATUS 4'h4

// ----------------------------------------------------------------------
// Control register fields (writes to CTRL are commands)
// ----------------------------------------------------------------------
`define FBC_CTRL_READ 0
`define FBC_CTRL_WRITE 1
`define FBC_CTRL_RESET 2
`define FBC_CTRL_SELECT 3

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define FBC_ST_BUSY 0
`define FBC_ST_READY 1
`define FBC_ST_DONE 2
`define FBC_ST_SELECT 3

// ----------------------------------------------------------------------
// Timing, in nanoseconds, and the clock period
// ----------------------------------------------------------------------
`define FBC_CLK_NS 20
`define FBC_SELECT_ACCESS_NS 120
`define FBC_GATE_ACCESS_NS 50
`define FBC_WRITE_PULSE_NS 50
`define FBC_RESET_PULSE_NS 500
`define FBC_RESET_RECOVERY_NS 50
`define FBC_RESET_SETTLE_NS 20000

`endif

// >>> logic/fbc_sync.v
// Two-stage synchroniser for pin inputs, one per bit of a vector.
// Assumes one clock domain; the first stage feeds only the second.
`timescale 1ns/100ps

module fbc_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk, // System clock.
   input wire sys_rst, // Asynchronous reset, active high.
   input wire ce, // Clock enable.
   input wire [WIDTH-1:0] din, // Asynchronous input.
   output reg [WIDTH-1:0] dout // Synchronised output.
);
   reg [WIDTH-1:0] stage1;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= INIT;
         dout <= INIT;
      end else if (ce) begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // fbc_sync

// >>> logic/fbc_ctrl.v
// Host-side controller driving a byte-wide parallel flash over its pins.
// Assumes a 50 MHz clock; software uses the simple strobe register port.
//
// Overview of operation
// RULE_01 - Read: select and gate low, strobe high
// RULE_02 - Write: strobe and select low, gate high
// RULE_03 - Command register has no address of its own
// RULE_04 - Device powers up in read-array mode
// RULE_05 - Read-array holds until a command is written
// RULE_06 - Identification sequence makes reads return codes
// RULE_07 - Erase targets sector, sectors or whole chip
// RULE_08 - Reads during program or erase return status
// RULE_09 - Standby tri-states data whatever the gate
// RULE_10 - Select and reset both high means standby
// RULE_11 - Wait full select access after standby
// RULE_12 - Reset low also means standby
// RULE_13 - Deselect does not abort embedded operation
// RULE_14 - Reset pulse aborts, tri-states, ignores cycles
// RULE_15 - Hardware reset returns to read-array mode
// RULE_16 - Host restarts operations that reset interrupted
// RULE_17 - Busy stays low until reset completes
// RULE_18 - Idle reset completes in shorter settle time
// RULE_19 - No read before reset recovery time elapses
// RULE_20 - Flash reset may follow system reset
// RULE_21 - Gate high means data lines high impedance
// RULE_22 - Sectors are 64 Kbytes, high address bits
// RULE_23 - Reset low overrides all other controls
`timescale 1ns/100ps
`include "fbc_defs.vh"

module fbc_ctrl #(
   parameter ADDR_W = 21,
   parameter SECTOR_BITS = 16,
   parameter RESET_SETTLE_NS = `FBC_RESET_SETTLE_NS
) (
   input wire clk, // System clock, 50 MHz.
   input wire sys_rst, // Asynchronous reset, active high.
   input wire ce, // Clock enable; low freezes all state.
   input wire [3:0] reg_addr, // Register address.
   input wire [31:0] reg_wdata, // Register write data.
   input wire reg_wr, // Register write strobe.
   input wire reg_rd, // Register read strobe.
   output reg [31:0] reg_rdata, // Read data, one cycle after strobe.
   output reg [ADDR_W-1:0] address_lines, // Flash address.
   input wire [7:0] data_lines_in, // Flash data, pin level.
   output reg [7:0] data_lines_out, // Flash data driven by host.
   output reg data_lines_oe, // High while host drives data.
   output reg select_n, // Flash device select, active low.
   output reg gate_n, // Flash output gate, active low.
   output reg strobe_n, // Flash write strobe, active low.
   output reg flash_reset_n, // Flash reset, active low.
   input wire busy_status_out // Flash ready (1) or busy (0).
);
   // -------------------------------------------------------------------
   // Timing counts
   // -------------------------------------------------------------------
   localparam integer SEL_CYC =
      (`FBC_SELECT_ACCESS_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
   localparam integer GATE_CYC =
      (`FBC_GATE_ACCESS_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
   localparam integer WP_CYC =
      (`FBC_WRITE_PULSE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
   localparam integer RP_CYC =
      (`FBC_RESET_PULSE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
   localparam integer RH_CYC =
      (`FBC_RESET_RECOVERY_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
   localparam integer SETTLE_CYC =
      (RESET_SETTLE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
   localparam CNT_W = 16;

   // -------------------------------------------------------------------
   // States
   // -------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_READ = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_WHOLD = 3'h3;
   localparam [2:0] ST_RPULSE = 3'h4;
   localparam [2:0] ST_RSETTLE = 3'h5;
   localparam [2:0] ST_RRECOV = 3'h6;

   reg [2:0] state;
   reg [CNT_W-1:0] cnt;
   reg [7:0] wdata;
   reg [7:0] rdata;
   reg keep_select;
   reg selected;
   reg done;
   reg ready;
   wire [7:0] data_sync;
   wire busy_sync;

   // -------------------------------------------------------------------
   // Pin input synchronisers
   // -------------------------------------------------------------------
   fbc_sync #(.WIDTH(9), .INIT(9'h100)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .din({busy_status_out, data_lines_in}),
      .dout({busy_sync, data_sync})
   );

   wire idle = (state == ST_IDLE);
   wire cmd_wr = reg_wr && (reg_addr == `FBC_REG_CTRL);
   wire go_read = cmd_wr && reg_wdata[`FBC_CTRL_READ] && idle && ready;
   wire go_write = cmd_wr && reg_wdata[`FBC_CTRL_WRITE] && idle && ready &&
      !reg_wdata[`FBC_CTRL_READ];
   wire go_reset = cmd_wr && reg_wdata[`FBC_CTRL_RESET];
   // Read wait covers select access unless already selected.
   wire [CNT_W-1:0] read_wait = selected ? GATE_CYC[CNT_W-1:0] + 2'd2 :
      SEL_CYC[CNT_W-1:0] + 2'd2; // RULE_11

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_RPULSE;
         cnt <= {CNT_W{1'b0}};
         address_lines <= {ADDR_W{1'b0}};
         wdata <= 8'h00;
         rdata <= 8'h00;
         data_lines_out <= 8'h00;
         data_lines_oe <= 1'b0;
         select_n <= 1'b1;
         gate_n <= 1'b1;
         strobe_n <= 1'b1;
         flash_reset_n <= 1'b0; // RULE_20
         keep_select <= 1'b0;
         selected <= 1'b0;
         done <= 1'b0;
         ready <= 1'b0;
      end else if (ce) begin
         if (reg_wr && reg_addr == `FBC_REG_ADDR)
            address_lines <= reg_wdata[ADDR_W-1:0];
         if (reg_wr && reg_addr == `FBC_REG_WDATA)
            wdata <= reg_wdata[7:0];
         if (cmd_wr)
            keep_select <= reg_wdata[`FBC_CTRL_SELECT];
         if (reg_rd && reg_addr == `FBC_REG_STATUS)
            done <= 1'b0;
         if (go_reset) begin
            // Reset has priority over any cycle in progress.
            state <= ST_RPULSE; // RULE_23
            cnt <= {CNT_W{1'b0}};
            flash_reset_n <= 1'b0; // RULE_14
            select_n <= 1'b1; // RULE_12
            gate_n <= 1'b1;
            strobe_n <= 1'b1;
            data_lines_oe <= 1'b0;
            selected <= 1'b0;
            ready <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (go_read) begin
                     state <= ST_READ;
                     cnt <= read_wait;
                     select_n <= 1'b0; // RULE_01
                     gate_n <= 1'b0;
                     strobe_n <= 1'b1;
                     data_lines_oe <= 1'b0;
                     selected <= 1'b1;
                  end else if (go_write) begin
                     state <= ST_WRITE;
                     cnt <= WP_CYC[CNT_W-1:0];
                     select_n <= 1'b0; // RULE_02
                     gate_n <= 1'b1; // RULE_21
                     strobe_n <= 1'b0;
                     data_lines_out <= wdata;
                     data_lines_oe <= 1'b1;
                     selected <= 1'b1;
                  end else if (!keep_select) begin
                     select_n <= 1'b1; // RULE_10
                     selected <= 1'b0;
                  end
               end
               ST_READ: begin
                  if (cnt == {CNT_W{1'b0}}) begin
                     // Data, array or status byte, passes the synchroniser.
                     rdata <= data_sync; // RULE_08
                     gate_n <= 1'b1;
                     done <= 1'b1;
                     state <= ST_IDLE;
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               ST_WRITE: begin
                  if (cnt <= 1) begin
                     strobe_n <= 1'b1;
                     state <= ST_WHOLD;
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               ST_WHOLD: begin
                  // Data held one cycle past the strobe's rising edge.
                  data_lines_oe <= 1'b0;
                  done <= 1'b1;
                  state <= ST_IDLE;
               end
               ST_RPULSE: begin
                  if (cnt >= RP_CYC[CNT_W-1:0] - 1'b1) begin
                     flash_reset_n <= 1'b1;
                     cnt <= {CNT_W{1'b0}};
                     state <= ST_RSETTLE;
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end
               ST_RSETTLE: begin
                  // Busy low means an aborted embedded operation settles.
                  if (busy_sync && cnt >= RH_CYC[CNT_W-1:0]) begin
                     state <= ST_RRECOV; // RULE_17
                     cnt <= {CNT_W{1'b0}};
                  end else if (cnt >= SETTLE_CYC[CNT_W-1:0]) begin
                     state <= ST_RRECOV; // RULE_18
                     cnt <= {CNT_W{1'b0}};
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end
               ST_RRECOV: begin
                  if (cnt >= RH_CYC[CNT_W-1:0]) begin
                     ready <= 1'b1; // RULE_19
                     done <= 1'b1; // RULE_16
                     state <= ST_IDLE;
                  end else begin
                     cnt <= cnt + 1'b1;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------
   // Register read port
   // -------------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `FBC_REG_CTRL:
                  reg_rdata[`FBC_CTRL_SELECT] <= keep_select;
               `FBC_REG_ADDR:
                  reg_rdata[ADDR_W-1:0] <= address_lines;
               `FBC_REG_WDATA:
                  reg_rdata[7:0] <= wdata;
               `FBC_REG_RDATA:
                  reg_rdata[7:0] <= rdata;
               `FBC_REG_STATUS: begin
                  reg_rdata[`FBC_ST_BUSY] <= !idle;
                  reg_rdata[`FBC_ST_READY] <= ready && busy_sync;
                  reg_rdata[`FBC_ST_DONE] <= done;
                  reg_rdata[`FBC_ST_SELECT] <= selected;
               end
               default:
                  reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // fbc_ctrl

// >>> bench/fbc_ctrl_monitor.sv
// Checker for fbc_ctrl pin sequencing on the flash side.
// Assumes ce is held high; the bind below reaches every instance.
`timescale 1ns/100ps
module fbc_ctrl_monitor (
   input logic clk, // Clock.
   input logic sys_rst, // Reset.
   input logic select_n, // Select.
   input logic gate_n, // Gate.
   input logic strobe_n, // Strobe.
   input logic data_lines_oe, // Drive.
   input logic flash_reset_n // Flash reset.
);
   logic [7:0] lo_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Counts reset-low cycles, saturating, to judge the pulse width.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         lo_cnt <= 8'h00;
      else if (flash_reset_n)
         lo_cnt <= 8'h00;
      else if (lo_cnt != 8'hff)
         lo_cnt <= lo_cnt + 8'h01;
   end
   sequence s_access;
      (!gate_n) [*8];
   endsequence
   sequence s_pulse;
      (!strobe_n) [*3] ##1 strobe_n;
   endsequence
   sequence s_hold;
      (data_lines_oe && !select_n) ##1 !data_lines_oe;
   endsequence
   rd_cycle_a: assert property (!gate_n |-> !select_n && strobe_n)
      else $error("read cycle pins wrong");
   wr_cycle_a: assert property (!strobe_n |-> !select_n && gate_n)
      else $error("write cycle pins wrong");
   wr_pulse_a: assert property ($fell(strobe_n) |-> s_pulse)
      else $error("write pulse length wrong");
   wr_hold_a: assert property ($rose(strobe_n) |-> s_hold)
      else $error("write data hold wrong");
   access_a: assert property ($fell(select_n) && !gate_n |-> s_access)
      else $error("read access too short");
   gate_access_a: assert property ($fell(gate_n) |-> (!gate_n) [*5])
      else $error("gate access too short");
   rst_quiet_a: assert property (!flash_reset_n |-> gate_n && strobe_n)
      else $error("cycle during flash reset");
   rst_width_a: assert property ($rose(flash_reset_n) |-> lo_cnt >= 8'd25)
      else $error("flash reset pulse too short");
   recover_a: assert property ($rose(flash_reset_n) |-> gate_n [*4])
      else $error("read inside reset recovery");
endmodule // fbc_ctrl_monitor

bind fbc_ctrl fbc_ctrl_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
   .select_n(select_n), .gate_n(gate_n), .strobe_n(strobe_n),
   .data_lines_oe(data_lines_oe), .flash_reset_n(flash_reset_n));

// >>> bench/fbc_flash_model.sv
// Behavioural byte-wide flash: array reads, byte writes, reset, busy pin.
// Assumes the host drives registered active-low control levels.
`timescale 1ns/100ps
module fbc_flash_model #(
   parameter [7:0] ID_CMD = 8'h90, // Enters identification mode.
   parameter [7:0] EXIT_CMD = 8'hf0, // Returns to read-array mode.
   parameter [7:0] ERASE_CMD = 8'h30, // Erases the addressed sector.
   parameter [7:0] ID_CODE = 8'h5e // Arbitrary identification code.
) (
   input wire [20:0] address_lines, // Address.
   input wire [7:0] data_lines_out, // Host data.
   input wire select_n, // Select.
   input wire gate_n, // Gate.
   input wire strobe_n, // Strobe.
   input wire flash_reset_n, // Reset.
   output wire [7:0] data_lines, // Read data.
   output reg busy_status_out // Ready high.
);
   reg [7:0] mem [0:255];
   reg [7:0] wa, wd;
   reg id_mode;
   integer gen, g, i, j;
   // The five sector bits pick a page, three low bits the byte in it.
   wire [7:0] idx = {address_lines[20:16], address_lines[2:0]};
   wire [7:0] q = !busy_status_out ? 8'h80 :
      id_mode ? ID_CODE : mem[idx];
   wire drv = flash_reset_n && !select_n && !gate_n && strobe_n;
   // Released lines show the inverse so a stale byte cannot pass.
   assign #60 data_lines = drv ? q : ~q;
   initial begin
      gen = 0;
      id_mode = 1'b0;
      busy_status_out = 1'b1;
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'ha5;
   end
   always @(posedge strobe_n) begin
      if (flash_reset_n && !select_n && gate_n) begin
         wa = idx;
         wd = data_lines_out;
         g = gen;
         if (wd == ID_CMD) begin
            id_mode = 1'b1;
         end else if (wd == EXIT_CMD) begin
            id_mode = 1'b0;
         end else begin
            busy_status_out = 1'b0;
            #300;
            if (g == gen) begin
               if (wd == ERASE_CMD) begin
                  for (j = 0; j < 8; j = j + 1)
                     mem[{wa[7:3], j[2:0]}] = 8'hff;
               end else begin
                  mem[wa] = wd;
               end
               busy_status_out = 1'b1;
            end
         end
      end
   end
   always @(negedge flash_reset_n) begin
      gen = gen + 1;
      id_mode = 1'b0;
      #100 busy_status_out = 1'b1;
   end
endmodule // fbc_flash_model

// >>> bench/test_fbc_ctrl.sv
// Testbench for fbc_ctrl driving the behavioural flash model.
// Assumes the register map and bits of fbc_defs.vh.
`timescale 1ns/100ps
`include "fbc_defs.vh"
module test_fbc_ctrl;
   reg clk, sys_rst, reg_wr, reg_rd;
   reg [3:0] reg_addr;
   reg [31:0] reg_wdata, d;
   wire [31:0] reg_rdata;
   wire [20:0] address_lines;
   wire [7:0] data_lines, data_lines_out;
   wire data_lines_oe, select_n, gate_n, strobe_n, flash_reset_n, busy;
   integer error_cnt, n_tests;
   // Model command bytes; the identification code value is arbitrary.
   localparam [7:0] ID_CMD = 8'h90;
   localparam [7:0] EXIT_CMD = 8'hf0;
   localparam [7:0] ERASE_CMD = 8'h30;
   localparam [7:0] ID_CODE = 8'h5e;
   fbc_ctrl #(.RESET_SETTLE_NS(200)) DUT (.clk(clk), .sys_rst(sys_rst),
      .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .address_lines(address_lines), .data_lines_in(data_lines),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .select_n(select_n), .gate_n(gate_n), .strobe_n(strobe_n),
      .flash_reset_n(flash_reset_n), .busy_status_out(busy));
   fbc_flash_model #(.ID_CMD(ID_CMD), .EXIT_CMD(EXIT_CMD),
      .ERASE_CMD(ERASE_CMD), .ID_CODE(ID_CODE)) flash (
      .address_lines(address_lines),
      .data_lines_out(data_lines_out), .select_n(select_n),
      .gate_n(gate_n), .strobe_n(strobe_n), .data_lines(data_lines),
      .flash_reset_n(flash_reset_n), .busy_status_out(busy));
   task chk(input string nm, input [31:0] e, input [31:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input [3:0] a, input [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task wt(input integer b);
      integer k;
      k = 0;
      d = 0;
      while (d[b] !== 1'b1 && k < 300) begin
         rd(`FBC_REG_STATUS);
         k = k + 1;
      end
      chk("status bit", 1, d[b]);
   endtask
   task fr(input [20:0] a, input [7:0] e);
      wr(`FBC_REG_ADDR, a);
      wr(`FBC_REG_CTRL, 32'h1);
      wt(`FBC_ST_DONE);
      chk("address", a, address_lines);
      rd(`FBC_REG_RDATA);
      chk("byte", e, d[7:0]);
   endtask
   task fw(input [20:0] a, input [7:0] v);
      wr(`FBC_REG_ADDR, a);
      wr(`FBC_REG_WDATA, v);
      wr(`FBC_REG_CTRL, 32'h2);
      wt(`FBC_ST_DONE);
   endtask
   task t_boot;
      wt(`FBC_ST_READY);
      fr(21'h33, 8'ha6);
      rd(4'hf);
      chk("unmapped", 0, d);
      $display("t_boot done");
   endtask
   task t_prog;
      fw(21'h1f0040, 8'h3c);
      fr(21'h1f0040, 8'h80);
      wt(`FBC_ST_READY);
      fr(21'h1f0040, 8'h3c);
      fr(21'h1f0040, 8'h3c);
      $display("t_prog done");
   endtask
   task t_keep;
      wr(`FBC_REG_ADDR, 21'h33);
      wr(`FBC_REG_CTRL, 32'h9);
      wt(`FBC_ST_DONE);
      chk("select held", 1, d[`FBC_ST_SELECT]);
      wr(`FBC_REG_CTRL, 32'h9);
      wt(`FBC_ST_DONE);
      rd(`FBC_REG_RDATA);
      chk("byte", 8'ha6, d[7:0]);
      wr(`FBC_REG_CTRL, 32'h0);
      rd(`FBC_REG_STATUS);
      chk("select freed", 0, d[`FBC_ST_SELECT]);
      chk("select pin", 1, select_n);
      $display("t_keep done");
   endtask
   task t_ident;
      fw(21'h0, ID_CMD);
      fr(21'h0, ID_CODE);
      fw(21'h0, EXIT_CMD);
      fr(21'h33, 8'ha6);
      fw(21'h1f0000, ERASE_CMD);
      wt(`FBC_ST_READY);
      fr(21'h1f0040, 8'hff);
      fr(21'h1e0000, 8'h55);
      $display("t_ident done");
   endtask
   task t_abort;
      fw(21'h10, 8'h5a);
      wr(`FBC_REG_CTRL, 32'h4);
      wt(`FBC_ST_READY);
      fr(21'h10, 8'ha5);
      fw(21'h10, 8'h5a);
      wt(`FBC_ST_READY);
      fr(21'h10, 8'h5a);
      $display("t_abort done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      error_cnt = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (5) @(posedge clk);
      chk("reset pin", 0, flash_reset_n);
      sys_rst <= 1'b0;
      t_boot;
      t_prog;
      t_keep;
      t_ident;
      t_abort;
      complete_run;
   end
   // Ample margin over the few hundred cycles the tests need.
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      complete_run;
   end
endmodule // test_fbc_ctrl
